// ===== shared/ccpc_consts.vh
// Purpose: constants for the core clock and power control block
// Assumes: 32-bit apb data, register byte address is four times the index
// Notes: behaviour summary follows
`ifndef CCPC_CONSTS_VH
`define CCPC_CONSTS_VH

`define CCPC_IDX_MSB 9
`define CCPC_IDX_LSB 2
`define CCPC_IDX_GEN_CTRL 8'h02
`define CCPC_IDX_PLL 8'h06
`define CCPC_IDX_WAKE_CNT 8'h08
`define CCPC_IDX_SLEEP 8'h09
`define CCPC_IDX_STBY_DIV 8'h10
`define CCPC_IDX_SW_DIV 8'h11
`define CCPC_IDX_STATUS 8'h12

`define CCPC_PLL_R_LSB 0
`define CCPC_PLL_R_MSB 5
`define CCPC_PLL_F_LSB 8
`define CCPC_PLL_F_MSB 19
`define CCPC_PLL_OD_LSB 24
`define CCPC_PLL_OD_MSB 26

`define CCPC_STRAP_00_OD 3'h1
`define CCPC_STRAP_00_F 12'h07A
`define CCPC_STRAP_11_F 12'h077
`define CCPC_STRAP_10_F 12'h031
`define CCPC_STRAP_01_F 12'h017
`define CCPC_STRAP_OD 3'h2
`define CCPC_STRAP_R 6'h00
`define CCPC_STRAP_SAMPLE_EDGE 2'h2

`define CCPC_GEN_REFCLK_BIT 0
`define CCPC_GEN_DIV_EN_BIT 4
`define CCPC_GEN_DIV_WAIT_BIT 5
`define CCPC_GEN_RESET 32'h00000000
`define CCPC_SLEEP_BIT 0

`define CCPC_REF_DIV_LAST 2'h3
`define CCPC_RETURN_SLOW_EDGES 3'h5
// five synchronised high cycles make 0.1 us at 20 ns; the qualifier counts 0 to 4
`define CCPC_WAKE_MIN_LAST 4'h4
`define CCPC_DIV_W 8

`endif

// ===== hw/ccpc_sleep_fsm.v
// Purpose: sleep state machine gating the core supply
// Assumes: all inputs already synchronised to ref_clk
// Notes: outputs are registered, state is one-hot
`timescale 1ns/1ps
module ccpc_sleep_fsm (
    input wire ref_clk,
    input wire rst,
    input wire fsm_reset_n_s,
    input wire sleep_req_s,
    input wire wake_ok,
    input wire count_zero,
    output reg gate_out,
    output reg gate_oe_n,
    output reg dec_en,
    output reg core_reset_n,
    output reg [2:0] state
);
    localparam ST_ACTIVE = 3'h1;
    localparam ST_SLEEP = 3'h2;
    localparam ST_ENERGISE = 3'h4;

    reg [2:0] state_next;

    always @*
    begin
        state_next = state;
        case (state)
            ST_ACTIVE:
            begin
                if (sleep_req_s)
                    state_next = ST_SLEEP;
            end
            ST_SLEEP:
            begin
                if (wake_ok || count_zero)
                    state_next = ST_ENERGISE;
            end
            ST_ENERGISE:
                state_next = ST_ENERGISE;
            default:
                state_next = ST_ACTIVE;
        endcase
        if (!fsm_reset_n_s)
            state_next = ST_ACTIVE;
    end

    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            state <= ST_ACTIVE;
            gate_out <= 1'b0;
            gate_oe_n <= 1'b1;
            dec_en <= 1'b0;
            core_reset_n <= 1'b1;
        end
        else
        begin
            state <= state_next;
            // only sleep drives the gate; energise keeps the core held in reset
            gate_out <= 1'b0;
            gate_oe_n <= (state_next != ST_SLEEP);
            dec_en <= (state_next == ST_SLEEP);
            core_reset_n <= (state_next == ST_ACTIVE);
        end
    end
endmodule

// ===== hw/ccpc_top.v
// Purpose: pll straps, standby divider, reference tick and sleep control
// Assumes: ref_clk is the core clock and the oscillator rate for counting
// Notes: zero-wait apb slave; pins pass two flops before use
//
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "ccpc_consts.vh"
module ccpc_top (
    input wire ref_clk,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire req_local,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [1:0] osc_select,
    input wire thread_active,
    input wire wake_pin,
    input wire sleep_fsm_reset_n,
    output reg [5:0] pll_ref_divider,
    output reg [11:0] pll_multiplier,
    output reg [2:0] pll_output_divider,
    output reg ref_tick,
    output reg refclk_from_core,
    output reg core_clk_en,
    output reg standby_active,
    output reg switch_clk_en,
    output reg supply_gate_out,
    output reg supply_gate_oe_n,
    output reg core_reset_n
);
    localparam [3:0] WAKE_MIN_LAST = `CCPC_WAKE_MIN_LAST;

    // pin and sleep request synchronisers
    reg [1:0] strap_m_reg;
    reg [1:0] strap_s_reg;
    reg wake_m_reg;
    reg wake_s_reg;
    reg fsmrst_m_reg;
    reg fsmrst_s_reg;
    reg sleep_m_reg;
    reg sleep_s_reg;

    // registers
    reg [31:0] gen_ctrl_reg;
    reg [`CCPC_DIV_W-1:0] stby_div_reg;
    reg [`CCPC_DIV_W-1:0] sw_div_reg;
    reg [31:0] wake_cnt_reg;
    reg sleep_req_reg;
    reg [1:0] strap_cnt_reg;
    reg strap_done_reg;
    reg [1:0] ref_cnt_reg;
    reg [`CCPC_DIV_W-1:0] sdiv_cnt_reg;
    reg [`CCPC_DIV_W-1:0] swdiv_cnt_reg;
    reg [2:0] ret_cnt_reg;
    reg [3:0] wake_hi_reg;
    reg wake_ok_reg;

    wire fsm_gate_out;
    wire fsm_gate_oe_n;
    wire fsm_dec_en;
    wire fsm_core_reset_n;
    wire [2:0] fsm_state;

    wire [7:0] idx = paddr[`CCPC_IDX_MSB:`CCPC_IDX_LSB];
    wire setup = psel && !penable;
    wire wr_take = psel && penable && pready && pwrite;
    wire protected_idx = (idx == `CCPC_IDX_WAKE_CNT) || (idx == `CCPC_IDX_SLEEP);
    wire wr_ok = wr_take && !(protected_idx && !req_local);
    // >= so that a smaller divisor written mid-count takes hold without a wrap
    wire slow_tick = (sdiv_cnt_reg >= stby_div_reg);
    wire div_en = gen_ctrl_reg[`CCPC_GEN_DIV_EN_BIT];
    wire div_wait = gen_ctrl_reg[`CCPC_GEN_DIV_WAIT_BIT];
    wire want_slow = div_en && (!div_wait || !thread_active);
    wire count_zero = fsm_dec_en && (wake_cnt_reg == 32'h00000000);

    reg mapped;
    reg [31:0] rd_mux;
    reg standby_next;

    always @*
    begin
        mapped = 1'b1;
        rd_mux = 32'h00000000;
        case (idx)
            `CCPC_IDX_GEN_CTRL:
                rd_mux = gen_ctrl_reg;
            `CCPC_IDX_PLL:
            begin
                rd_mux[`CCPC_PLL_R_MSB:`CCPC_PLL_R_LSB] = pll_ref_divider;
                rd_mux[`CCPC_PLL_F_MSB:`CCPC_PLL_F_LSB] = pll_multiplier;
                rd_mux[`CCPC_PLL_OD_MSB:`CCPC_PLL_OD_LSB] = pll_output_divider;
            end
            `CCPC_IDX_WAKE_CNT:
                rd_mux = wake_cnt_reg;
            `CCPC_IDX_SLEEP:
                rd_mux[`CCPC_SLEEP_BIT] = sleep_req_reg;
            `CCPC_IDX_STBY_DIV:
                rd_mux[`CCPC_DIV_W-1:0] = stby_div_reg;
            `CCPC_IDX_SW_DIV:
                rd_mux[`CCPC_DIV_W-1:0] = sw_div_reg;
            `CCPC_IDX_STATUS:
                rd_mux = {26'h0000000, wake_ok_reg, strap_done_reg, fsm_state,
                    standby_active};
            default:
                mapped = 1'b0;
        endcase
    end

    // apb slave: pready rises in the first access cycle, so no wait states
    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end
        else
        begin
            pready <= setup;
            pslverr <= setup && (!mapped || (pwrite && protected_idx && !req_local));
            if (setup && !pwrite)
                prdata <= rd_mux;
        end
    end

    // two-flop synchronisers for pins and the sleep request
    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            strap_m_reg <= 2'h0;
            strap_s_reg <= 2'h0;
            wake_m_reg <= 1'b0;
            wake_s_reg <= 1'b0;
            fsmrst_m_reg <= 1'b0;
            fsmrst_s_reg <= 1'b0;
            sleep_m_reg <= 1'b0;
            sleep_s_reg <= 1'b0;
        end
        else
        begin
            strap_m_reg <= osc_select;
            strap_s_reg <= strap_m_reg;
            wake_m_reg <= wake_pin;
            wake_s_reg <= wake_m_reg;
            fsmrst_m_reg <= sleep_fsm_reset_n;
            fsmrst_s_reg <= fsmrst_m_reg;
            sleep_m_reg <= sleep_req_reg;
            sleep_s_reg <= sleep_m_reg;
        end
    end

    // wake pin qualifier: a glitch shorter than the minimum never wakes
    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            wake_hi_reg <= 4'h0;
            wake_ok_reg <= 1'b0;
        end
        else if (!wake_s_reg)
        begin
            wake_hi_reg <= 4'h0;
            wake_ok_reg <= 1'b0;
        end
        else if (wake_hi_reg == WAKE_MIN_LAST)
            wake_ok_reg <= 1'b1;
        else
            wake_hi_reg <= wake_hi_reg + 4'h1;
    end

    // straps sampled on a fixed edge after release; the board holds them meanwhile
    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            strap_cnt_reg <= 2'h0;
            strap_done_reg <= 1'b0;
        end
        else if (!strap_done_reg)
        begin
            strap_cnt_reg <= strap_cnt_reg + 2'h1;
            if (strap_cnt_reg == `CCPC_STRAP_SAMPLE_EDGE)
                strap_done_reg <= 1'b1;
        end
    end

    // pll fields: loaded from straps, later rewritable by software
    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            pll_ref_divider <= `CCPC_STRAP_R;
            pll_multiplier <= `CCPC_STRAP_00_F;
            pll_output_divider <= `CCPC_STRAP_00_OD;
        end
        else if (!strap_done_reg && strap_cnt_reg == `CCPC_STRAP_SAMPLE_EDGE)
        begin
            pll_ref_divider <= `CCPC_STRAP_R;
            case (strap_s_reg)
                2'h0:
                begin
                    pll_multiplier <= `CCPC_STRAP_00_F;
                    pll_output_divider <= `CCPC_STRAP_00_OD;
                end
                2'h3:
                begin
                    pll_multiplier <= `CCPC_STRAP_11_F;
                    pll_output_divider <= `CCPC_STRAP_OD;
                end
                2'h2:
                begin
                    pll_multiplier <= `CCPC_STRAP_10_F;
                    pll_output_divider <= `CCPC_STRAP_OD;
                end
                default:
                begin
                    pll_multiplier <= `CCPC_STRAP_01_F;
                    pll_output_divider <= `CCPC_STRAP_OD;
                end
            endcase
        end
        else if (wr_ok && idx == `CCPC_IDX_PLL)
        begin
            // fields land unchecked: the frequency limits are software's to keep
            pll_ref_divider <= pwdata[`CCPC_PLL_R_MSB:`CCPC_PLL_R_LSB];
            pll_multiplier <= pwdata[`CCPC_PLL_F_MSB:`CCPC_PLL_F_LSB];
            pll_output_divider <= pwdata[`CCPC_PLL_OD_MSB:`CCPC_PLL_OD_LSB];
        end
    end

    // control, divisor and sleep registers
    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            gen_ctrl_reg <= `CCPC_GEN_RESET;
            stby_div_reg <= {`CCPC_DIV_W{1'b0}};
            sw_div_reg <= {`CCPC_DIV_W{1'b0}};
            sleep_req_reg <= 1'b0;
        end
        else
        begin
            if (wr_ok && idx == `CCPC_IDX_GEN_CTRL)
                gen_ctrl_reg <= pwdata;
            if (wr_ok && idx == `CCPC_IDX_STBY_DIV)
                stby_div_reg <= pwdata[`CCPC_DIV_W-1:0];
            if (wr_ok && idx == `CCPC_IDX_SW_DIV)
                sw_div_reg <= pwdata[`CCPC_DIV_W-1:0];
            if (wr_ok && idx == `CCPC_IDX_SLEEP && pwdata[`CCPC_SLEEP_BIT])
                sleep_req_reg <= 1'b1;
            else if (fsm_state[1])
                sleep_req_reg <= 1'b0;
        end
    end

    // wake counter: loads on write, counts down only while asleep
    always @(posedge ref_clk)
    begin
        if (rst)
            wake_cnt_reg <= 32'h00000000;
        else if (wr_ok && idx == `CCPC_IDX_WAKE_CNT)
            wake_cnt_reg <= pwdata;
        else if (fsm_dec_en && wake_cnt_reg != 32'h00000000)
            wake_cnt_reg <= wake_cnt_reg - 32'h00000001;
    end

    // reference and switch ticks ignore standby so timers keep running
    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            ref_cnt_reg <= 2'h0;
            ref_tick <= 1'b0;
            swdiv_cnt_reg <= {`CCPC_DIV_W{1'b0}};
            switch_clk_en <= 1'b0;
            refclk_from_core <= 1'b0;
        end
        else
        begin
            ref_cnt_reg <= ref_cnt_reg + 2'h1;
            ref_tick <= (ref_cnt_reg == `CCPC_REF_DIV_LAST);
            refclk_from_core <= gen_ctrl_reg[`CCPC_GEN_REFCLK_BIT];
            if (swdiv_cnt_reg >= sw_div_reg)
            begin
                swdiv_cnt_reg <= {`CCPC_DIV_W{1'b0}};
                switch_clk_en <= 1'b1;
            end
            else
            begin
                swdiv_cnt_reg <= swdiv_cnt_reg + {{(`CCPC_DIV_W-1){1'b0}}, 1'b1};
                switch_clk_en <= 1'b0;
            end
        end
    end

    // standby selection; leaving dynamic standby waits a fixed count of slow edges
    always @*
    begin
        standby_next = standby_active;
        if (!div_en)
            standby_next = 1'b0;
        else if (!standby_active && want_slow)
            standby_next = 1'b1;
        else if (standby_active && !want_slow && slow_tick
            && ret_cnt_reg == `CCPC_RETURN_SLOW_EDGES - 3'h1)
            standby_next = 1'b0;
    end

    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            standby_active <= 1'b0;
            sdiv_cnt_reg <= {`CCPC_DIV_W{1'b0}};
            ret_cnt_reg <= 3'h0;
            core_clk_en <= 1'b1;
        end
        else
        begin
            standby_active <= standby_next;
            if (slow_tick)
                sdiv_cnt_reg <= {`CCPC_DIV_W{1'b0}};
            else
                sdiv_cnt_reg <= sdiv_cnt_reg + {{(`CCPC_DIV_W-1){1'b0}}, 1'b1};
            if (!standby_active || want_slow)
                ret_cnt_reg <= 3'h0;
            else if (slow_tick)
                ret_cnt_reg <= ret_cnt_reg + 3'h1;
            // zero divisor makes every cycle a slow tick, so no division
            core_clk_en <= !standby_next || slow_tick;
        end
    end

    ccpc_sleep_fsm u_fsm (
        .ref_clk(ref_clk),
        .rst(rst),
        .fsm_reset_n_s(fsmrst_s_reg),
        .sleep_req_s(sleep_s_reg),
        .wake_ok(wake_ok_reg),
        .count_zero(count_zero),
        .gate_out(fsm_gate_out),
        .gate_oe_n(fsm_gate_oe_n),
        .dec_en(fsm_dec_en),
        .core_reset_n(fsm_core_reset_n),
        .state(fsm_state)
    );

    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            supply_gate_out <= 1'b0;
            supply_gate_oe_n <= 1'b1;
            core_reset_n <= 1'b1;
        end
        else
        begin
            supply_gate_out <= fsm_gate_out;
            supply_gate_oe_n <= fsm_gate_oe_n;
            core_reset_n <= fsm_core_reset_n;
        end
    end
endmodule

// ===== dv/ccpc_top_properties.sv
// Purpose: port-level assertions for the clock and power control block
// Assumes: one clock domain, synchronous active-high reset
// Notes: latencies follow the two-flop pin synchronisers
`timescale 1ns/1ps
module ccpc_props (
    input wire ref_clk,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire req_local,
    input wire pready,
    input wire pslverr,
    input wire [1:0] osc_select,
    input wire wake_pin,
    input wire sleep_fsm_reset_n,
    input wire [11:0] pll_multiplier,
    input wire ref_tick,
    input wire supply_gate_out,
    input wire supply_gate_oe_n,
    input wire core_reset_n
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    wire commit = psel && penable && pready && pwrite;
    function automatic logic [11:0] strap_f(input logic [1:0] c);
        return (c == 2'h0) ? 12'h07A : (c == 2'h3) ? 12'h077 : (c == 2'h2) ? 12'h031 : 12'h017;
    endfunction
    property p_strap;
        $fell(rst) |-> ##[2:5] pll_multiplier == strap_f(osc_select);
    endproperty
    a_strap: assert property (p_strap)
        else $error("strap multiplier not loaded");
    property p_ref_tick;
        ref_tick |=> !ref_tick [*3] ##1 ref_tick;
    endproperty
    a_ref_tick: assert property (p_ref_tick)
        else $error("reference tick not every fourth cycle");
    property p_local_only;
        commit && (paddr[9:2] == 8'h08 || paddr[9:2] == 8'h09) && !req_local |-> pslverr;
    endproperty
    a_local_only: assert property (p_local_only)
        else $error("remote write to power register not refused");
    property p_sleep_entry;
        commit && paddr[9:2] == 8'h09 && pwdata[0] && req_local && core_reset_n
            && sleep_fsm_reset_n |-> ##[3:7] !supply_gate_oe_n;
    endproperty
    a_sleep_entry: assert property (p_sleep_entry)
        else $error("sleep request did not gate the supply");
    property p_sleep_out;
        !supply_gate_oe_n |-> !core_reset_n && !supply_gate_out;
    endproperty
    a_sleep_out: assert property (p_sleep_out)
        else $error("sleep outputs wrong");
    property p_wake;
        (!supply_gate_oe_n && wake_pin) [*5] |-> ##[1:5] supply_gate_oe_n;
    endproperty
    a_wake: assert property (p_wake)
        else $error("long wake pulse ignored");
    property p_energise;
        $rose(supply_gate_oe_n) && !core_reset_n |=> !core_reset_n [*2];
    endproperty
    a_energise: assert property (p_energise)
        else $error("core reset released before power-on reset");
    property p_fsm_reset;
        !sleep_fsm_reset_n [*3] |-> ##[1:3] core_reset_n && supply_gate_oe_n;
    endproperty
    a_fsm_reset: assert property (p_fsm_reset)
        else $error("fsm reset did not return to active");
endmodule
bind ccpc_top ccpc_props u_props (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .req_local, .pready, .pslverr, .osc_select, .wake_pin, .sleep_fsm_reset_n,
    .pll_multiplier, .ref_tick, .supply_gate_out, .supply_gate_oe_n, .core_reset_n);

// ===== dv/ccpc_supply_model.sv
// Purpose: supply gating transistor and wake source beside the block
// Assumes: gate line pulled up, so a floating gate powers the core
// Notes: power return triggers a power-on reset of the sleep fsm
`timescale 1ns/1ps
module ccpc_supply_model (
    input wire ref_clk,
    input wire supply_gate_out,
    input wire supply_gate_oe_n,
    input wire wake_go,
    input wire [3:0] wake_len,
    output logic wake_pin = 1'b0,
    output logic sleep_fsm_reset_n = 1'b0
);
    logic vdd_ok = 1'b1;
    int por = 6;
    int wk = 0;
    wire gate_level = supply_gate_oe_n | supply_gate_out;
    always @(posedge ref_clk)
    begin
        vdd_ok <= gate_level;
        // supply ramps for six cycles, then reset is held low six cycles
        if (!vdd_ok && gate_level)
            por <= 12;
        else if (por > 0)
            por <= por - 1;
        sleep_fsm_reset_n <= !(por > 0 && por <= 6);
        // pulse width is chosen by the bench, short ones may be swallowed
        if (wake_go)
            wk <= wake_len;
        else if (wk > 0)
            wk <= wk - 1;
        wake_pin <= wake_go ? 1'b1 : (wk > 1);
    end
endmodule

// ===== dv/tb_core_clock_power_control.sv
// Purpose: self-checking bench for the clock and power control block
// Assumes: zero-wait apb slave, supply model on the far side
// Notes: random values come from a fixed seed
`timescale 1ns/1ps
module tb_core_clock_power_control;
    logic ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic req_local = 1'b1, thread_active = 1'b0, wake_go = 1'b0, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, rd, rnd;
    logic [1:0] osc_select = 2'h3;
    logic [3:0] wake_len = 4'h0;
    wire [31:0] prdata;
    wire [5:0] pll_ref_divider;
    wire [11:0] pll_multiplier;
    wire [2:0] pll_output_divider;
    wire pready, pslverr, wake_pin, sleep_fsm_reset_n, ref_tick, refclk_from_core;
    wire core_clk_en, standby_active, switch_clk_en, supply_gate_out, supply_gate_oe_n;
    wire core_reset_n;
    int n_fail = 0, checks = 0, n, k, t;
    always #10 ref_clk = ~ref_clk;
    ccpc_top dut (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .req_local,
        .prdata, .pready, .pslverr, .osc_select, .thread_active, .wake_pin,
        .sleep_fsm_reset_n, .pll_ref_divider, .pll_multiplier, .pll_output_divider, .ref_tick,
        .refclk_from_core, .core_clk_en, .standby_active, .switch_clk_en, .supply_gate_out,
        .supply_gate_oe_n, .core_reset_n);
    ccpc_supply_model far (.ref_clk, .supply_gate_out, .supply_gate_oe_n, .wake_go,
        .wake_len, .wake_pin, .sleep_fsm_reset_n);
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] d);
        int w;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        w = 0;
        do
        begin
            @(posedge ref_clk);
            w++;
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk("wait states", w, 1);
    endtask
    task automatic count(input int sel, input int cyc, output int c);
        c = 0;
        repeat (cyc)
        begin
            @(posedge ref_clk);
            if ((sel == 0 ? core_clk_en : sel == 1 ? ref_tick : switch_clk_en) === 1'b1)
                c++;
        end
    endtask
    task automatic wait_for(input int sel, input logic v, input int lim);
        t = 0;
        while ((sel == 0 ? supply_gate_oe_n : core_reset_n) !== v && t < lim)
        begin
            @(posedge ref_clk);
            t++;
        end
        chk(sel == 0 ? "gate" : "core reset", sel == 0 ? supply_gate_oe_n : core_reset_n, v);
    endtask
    task automatic do_reset(input logic [1:0] code);
        osc_select <= code;
        rst <= 1'b1;
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (8) @(posedge ref_clk);
    endtask
    task automatic pulse(input logic [3:0] len);
        wake_len <= len;
        wake_go <= 1'b1;
        @(posedge ref_clk);
        wake_go <= 1'b0;
    endtask
    function automatic logic [31:0] pll_word(input logic [1:0] c);
        logic [11:0] f;
        f = (c == 2'h0) ? 12'h07A : (c == 2'h3) ? 12'h077 : (c == 2'h2) ? 12'h031 : 12'h017;
        return {5'h00, (c == 2'h0) ? 3'h1 : 3'h2, 4'h0, f, 8'h00};
    endfunction
    function automatic logic [31:0] pins();
        return {5'h00, pll_output_divider, 4'h0, pll_multiplier, 2'h0, pll_ref_divider};
    endfunction
    initial
    begin
        #400000;
        n_fail++;
        wrap_up();
    end
    initial
    begin
        void'($urandom(32'h70EC));
        for (int c = 3; c >= 0; c--)
        begin
            do_reset(c[1:0]);
            chk("pll pins", pins(), pll_word(c[1:0]));
        end
        rnd = $urandom;
        // multiplier 119, ref divider 0, output divider 2..7 keep vco and core legal
        rnd[26:0] = {3'h2 + rnd[26:24] % 3'h6, rnd[23:20], 12'h077, rnd[7:6], 6'h00};
        apb(1, 8'h06, rnd);
        apb(0, 8'h06, 0);
        chk("pll pins w", pins(), rnd & 32'h070FFF3F);
        chk("pll read", rd, rnd & 32'h070FFF3F);
        apb(0, 8'h3F, 0);
        chk("unmapped err", err, 1);
        chk("unmapped data", rd, 0);
        count(1, 40, k);
        chk("ref ticks", k, 10);
        for (int i = 0; i < 3; i++)
        begin
            n = (i == 0) ? 0 : (i == 1) ? 3 : 1 + $urandom % 7;
            apb(1, 8'h10, n);
            apb(1, 8'h02, 32'h00000010);
            repeat (3) @(posedge ref_clk);
            count(0, 8 * (n + 1), k);
            chk("slow clock", k, 8);
        end
        count(1, 40, k);
        chk("ticks in standby", k, 10);
        for (int i = 0; i < 2; i++)
        begin
            apb(1, 8'h02, i << 5);
            repeat (3) @(posedge ref_clk);
            chk("no standby", standby_active, 0);
            count(0, 20, k);
            chk("full speed", k, 20);
        end
        apb(1, 8'h02, 32'h00000031);
        repeat (3) @(posedge ref_clk);
        chk("dyn idle", standby_active, 1);
        chk("refclk sel", refclk_from_core, 1);
        thread_active <= 1'b1;
        t = 0;
        do
        begin
            @(posedge ref_clk);
            t++;
        end while (standby_active === 1'b1 && t < 100);
        chk("dyn return", t >= 4 * (n + 1) && t <= 8 * (n + 1) + 2, 1);
        count(0, 10, k);
        chk("dyn busy", k, 10);
        thread_active <= 1'b0;
        n = $urandom % 6;
        apb(1, 8'h11, n);
        repeat (3) @(posedge ref_clk);
        count(2, 6 * (n + 1), k);
        chk("switch ticks", k, 6);
        req_local <= 1'b0;
        apb(1, 8'h09, 1);
        chk("remote sleep", err, 1);
        req_local <= 1'b1;
        repeat (10) @(posedge ref_clk);
        chk("still powered", supply_gate_oe_n, 1);
        apb(1, 8'h08, 30);
        chk("wake idle", wake_pin, 0);
        apb(1, 8'h09, 1);
        wait_for(0, 0, 12);
        chk("reset asleep", core_reset_n, 0);
        wait_for(0, 1, 40);
        chk("timed wake", t >= 26 && t <= 34, 1);
        chk("energise reset", core_reset_n, 0);
        wait_for(1, 1, 30);
        apb(0, 8'h12, 0);
        chk("fsm active", rd[3:1], 3'h1);
        apb(1, 8'h08, 32'hFFFFFFFF);
        apb(1, 8'h09, 1);
        wait_for(0, 0, 12);
        pulse(3);
        repeat (20) @(posedge ref_clk);
        chk("short pulse", supply_gate_oe_n, 0);
        pulse(5);
        wait_for(0, 1, 15);
        wait_for(1, 1, 30);
        rnd = $urandom;
        do_reset(rnd[1:0]);
        chk("pll again", pins(), pll_word(rnd[1:0]));
        wrap_up();
    end
endmodule
